// File: rtl/imdau_pkg.sv
// Shared constants for the multiply/divide/accumulate unit
package imdau_pkg;

  // Operation codes presented by the issue logic
  typedef enum logic [3:0] {
    IMDAU_OP_NONE   = 4'h0,
    IMDAU_OP_SPROD  = 4'h1, // signed_product_to_accum_pair
    IMDAU_OP_UPROD  = 4'h2, // unsigned_product_to_accum_pair
    IMDAU_OP_MADD   = 4'h3, // product_add_accum, signed
    IMDAU_OP_MADDU  = 4'h4, // product_add_accum, unsigned
    IMDAU_OP_MSUBS  = 4'h5, // product_subtract_accum, signed
    IMDAU_OP_MSUBU  = 4'h6, // product_subtract_accum, unsigned
    IMDAU_OP_PREG   = 4'h7, // product_to_register
    IMDAU_OP_DIVS   = 4'h8, // signed quotient
    IMDAU_OP_UQUO   = 4'h9, // unsigned_quotient_op
    IMDAU_OP_RDTOP  = 4'ha, // read_upper_accum
    IMDAU_OP_RDBOT  = 4'hb  // read_bottom_accum
  } imdau_op_t;

  // Unit states, Gray coded along idle -> busy -> done
  typedef enum logic [1:0] {
    IMDAU_ST_IDLE = 2'b00,
    IMDAU_ST_BUSY = 2'b01,
    IMDAU_ST_DONE = 2'b11
  } imdau_state_t;

  // Timing in pipeline clocks
  localparam logic [5:0] IMDAU_LAT_SHORT = 6'h03;
  localparam logic [5:0] IMDAU_LAT_LONG = 6'h04;
  localparam logic [5:0] IMDAU_REP_SHORT = 6'h02;
  localparam logic [5:0] IMDAU_REP_LONG = 6'h03;
  localparam logic [5:0] IMDAU_DIV_CYC = 6'h24;
  localparam logic [1:0] IMDAU_STALL_SHORT = 2'h1;
  localparam logic [1:0] IMDAU_STALL_LONG = 2'h2;
  localparam logic [5:0] IMDAU_CNT_ONE = 6'h01;
  localparam logic [5:0] IMDAU_CNT_ZERO = 6'h00;

  // Register file and word layout
  localparam int IMDAU_WORD_W = 32;
  localparam int IMDAU_HALF_W = 16;
  localparam int IMDAU_NREGS = 32;
  localparam int IMDAU_IDX_W = 5;
  localparam logic [31:0] IMDAU_RESET_WORD = 32'h0000_0000;

endpackage : imdau_pkg

// File: rtl/imdau_regfile.sv
`timescale 1ns/10ps
// General register file, two read and two write ports, bypassed
module imdau_regfile
  import imdau_pkg::*;
#(
  parameter int NREGS = IMDAU_NREGS,
  parameter int AW = IMDAU_IDX_W,
  parameter int DW = IMDAU_WORD_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [AW-1:0] rd_a_idx,
  output logic [DW-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_idx,
  output logic [DW-1:0] rd_b_data,
  input wire logic wr0_en,
  input wire logic [AW-1:0] wr0_idx,
  input wire logic [DW-1:0] wr0_data,
  input wire logic wr1_en,
  input wire logic [AW-1:0] wr1_idx,
  input wire logic [DW-1:0] wr1_data
);

  // Storage in flip-flops
  logic [DW-1:0] mem [NREGS];

  // per-entry write, port 1 wins a same-index clash
  for (genvar g = 0; g < NREGS; g++) begin : g_ent
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        mem[g] <= '0;
      end else if (wr1_en && wr1_idx == AW'(g)) begin
        mem[g] <= wr1_data;
      end else if (wr0_en && wr0_idx == AW'(g)) begin
        mem[g] <= wr0_data;
      end
    end
  end

  // full bypass from both write ports
  always_comb begin
    rd_a_data = mem[rd_a_idx];
    if (wr0_en && wr0_idx == rd_a_idx) begin
      rd_a_data = wr0_data;
    end
    if (wr1_en && wr1_idx == rd_a_idx) begin
      rd_a_data = wr1_data;
    end
    rd_b_data = mem[rd_b_idx];
    if (wr0_en && wr0_idx == rd_b_idx) begin
      rd_b_data = wr0_data;
    end
    if (wr1_en && wr1_idx == rd_b_idx) begin
      rd_b_data = wr1_data;
    end
  end

endmodule // imdau_regfile

// File: rtl/imdau_unit.sv
`timescale 1ns/10ps
// Functional notes
// - Accumulate-class result after 3 or 4 clocks
// - Reissue spacing 2, 3, or 36 clocks
// - Register product stalls 1 or 2 clocks
// - Divide finishes 36 clocks after issue
// - Multiply (except register product) and divide results go to accumulators
// - Read instructions copy accumulators to registers
// - Register product writes destination, skips accumulator
// - Add-accumulate adds product to pair atomically
// - Subtract-accumulate subtracts product from pair atomically
// - New operation may issue before previous finishes
// - Operand size detected from values automatically
// - Interlocks hold dependents until results valid
// - Register file 32x32, 2R2W, fully bypassed
// - Adder and logic finish in one cycle
module imdau_unit
  import imdau_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [3:0] issue_op,
  input wire logic [IMDAU_IDX_W-1:0] src_a_idx,
  input wire logic [IMDAU_IDX_W-1:0] src_b_idx,
  input wire logic [IMDAU_IDX_W-1:0] dst_idx,
  input wire logic alu_wr_en,
  input wire logic [IMDAU_IDX_W-1:0] alu_wr_idx,
  input wire logic [IMDAU_WORD_W-1:0] alu_wr_data,
  output logic issue_ready,
  output logic stall,
  output logic result_valid,
  output logic [IMDAU_WORD_W-1:0] top_accum_reg,
  output logic [IMDAU_WORD_W-1:0] bottom_accum_reg,
  output logic [IMDAU_WORD_W-1:0] src_a_data,
  output logic [IMDAU_WORD_W-1:0] src_b_data
);

  // Operand reads, straight from the bypassed file
  logic [IMDAU_WORD_W-1:0] rd_a;
  logic [IMDAU_WORD_W-1:0] rd_b;
  // Unit-side write port (read-accumulator and register product)
  logic unit_wr_en;
  logic [IMDAU_IDX_W-1:0] unit_wr_idx;
  logic [IMDAU_WORD_W-1:0] unit_wr_data;

  imdau_regfile #(
    .NREGS(IMDAU_NREGS),
    .AW(IMDAU_IDX_W),
    .DW(IMDAU_WORD_W)
  ) u_rf (
    .core_clk(core_clk),
    .rst(rst),
    .rd_a_idx(src_a_idx),
    .rd_a_data(rd_a),
    .rd_b_idx(src_b_idx),
    .rd_b_data(rd_b),
    .wr0_en(alu_wr_en),
    .wr0_idx(alu_wr_idx),
    .wr0_data(alu_wr_data),
    .wr1_en(unit_wr_en),
    .wr1_idx(unit_wr_idx),
    .wr1_data(unit_wr_data)
  );

  // Decoded issue
  imdau_op_t op;
  logic is_mul;
  logic is_div;
  logic is_rd;
  logic is_signed;
  logic short_ops;
  logic take;
  assign op = imdau_op_t'(issue_op);
  assign is_mul = (op == IMDAU_OP_SPROD) || (op == IMDAU_OP_UPROD) ||
                  (op == IMDAU_OP_MADD) || (op == IMDAU_OP_MADDU) ||
                  (op == IMDAU_OP_MSUBS) || (op == IMDAU_OP_MSUBU) ||
                  (op == IMDAU_OP_PREG);
  assign is_div = (op == IMDAU_OP_DIVS) || (op == IMDAU_OP_UQUO);
  assign is_rd = (op == IMDAU_OP_RDTOP) || (op == IMDAU_OP_RDBOT);
  assign is_signed = (op == IMDAU_OP_SPROD) || (op == IMDAU_OP_MADD) ||
                     (op == IMDAU_OP_MSUBS) || (op == IMDAU_OP_PREG) ||
                     (op == IMDAU_OP_DIVS);

  // operand fits 16 bits when upper half is pure extension
  function automatic logic fits16(input logic [31:0] v, input logic sgn);
    logic ext;
    ext = sgn & v[IMDAU_HALF_W-1];
    fits16 = (v[31:IMDAU_HALF_W] == {IMDAU_HALF_W{ext}});
  endfunction
  assign short_ops = fits16(rd_a, is_signed) && fits16(rd_b, is_signed);

  // Pipeline state
  imdau_state_t state;
  logic [5:0] rep_cnt;   // Clocks until next issue allowed
  logic [5:0] lat_cnt;   // Clocks until result lands
  logic [1:0] stall_cnt; // Remaining forced stall clocks
  imdau_op_t p_op;
  logic [IMDAU_IDX_W-1:0] p_dst;
  logic [63:0] p_prod;
  logic [31:0] p_quo;
  logic [31:0] p_rem;

  // accept only when repeat window and result interlock allow
  // reads wait for a pending result so they never see stale values
  assign take = issue_valid && issue_ready && !(is_rd && state == IMDAU_ST_BUSY);

  // Product and quotient of the issued operands
  logic signed [63:0] next_prod;
  logic [31:0] next_quo;
  logic [31:0] next_rem;
  always_comb begin
    // sign or zero extend before the multiply
    if (is_signed) begin
      next_prod = $signed({{32{rd_a[31]}}, rd_a}) * $signed({{32{rd_b[31]}}, rd_b});
    end else begin
      next_prod = $signed({32'h0000_0000, rd_a} * {32'h0000_0000, rd_b});
    end
    // Divide by zero yields all-ones quotient and dividend remainder
    if (rd_b == IMDAU_RESET_WORD) begin
      next_quo = 32'hffff_ffff;
      next_rem = rd_a;
    end else if (is_signed) begin
      next_quo = 32'($signed(rd_a) / $signed(rd_b));
      next_rem = 32'($signed(rd_a) % $signed(rd_b));
    end else begin
      next_quo = rd_a / rd_b;
      next_rem = rd_a % rd_b;
    end
  end

  // State machine and counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= IMDAU_ST_IDLE;
      lat_cnt <= IMDAU_CNT_ZERO;
    end else begin
      case (state)
        IMDAU_ST_IDLE, IMDAU_ST_DONE: begin
          state <= IMDAU_ST_IDLE;
          if (take && (is_mul || is_div)) begin
            state <= IMDAU_ST_BUSY;
            lat_cnt <= is_div ? IMDAU_DIV_CYC - IMDAU_CNT_ONE :
                       (short_ops ? IMDAU_LAT_SHORT : IMDAU_LAT_LONG) - IMDAU_CNT_ONE;
          end
        end
        IMDAU_ST_BUSY: begin
          if (take && (is_mul || is_div)) begin
            // new issue on the older op's landing edge
            lat_cnt <= is_div ? IMDAU_DIV_CYC - IMDAU_CNT_ONE :
                       (short_ops ? IMDAU_LAT_SHORT : IMDAU_LAT_LONG) - IMDAU_CNT_ONE;
          end else if (lat_cnt == IMDAU_CNT_ONE) begin
            state <= IMDAU_ST_DONE;
            lat_cnt <= IMDAU_CNT_ZERO;
          end else begin
            lat_cnt <= lat_cnt - IMDAU_CNT_ONE;
          end
        end
        default: begin
          state <= IMDAU_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rep_cnt <= IMDAU_CNT_ZERO;
      issue_ready <= 1'b1;
    end else if (take && (is_mul || is_div)) begin
      rep_cnt <= is_div ? IMDAU_DIV_CYC - IMDAU_CNT_ONE :
                 (short_ops ? IMDAU_REP_SHORT : IMDAU_REP_LONG) - IMDAU_CNT_ONE;
      issue_ready <= 1'b0;
    end else if (rep_cnt > IMDAU_CNT_ONE) begin
      rep_cnt <= rep_cnt - IMDAU_CNT_ONE;
    end else begin
      rep_cnt <= IMDAU_CNT_ZERO;
      issue_ready <= 1'b1;
    end
  end

  // forced stall only for register product
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stall_cnt <= 2'h0;
      stall <= 1'b0;
    end else if (take && op == IMDAU_OP_PREG) begin
      stall_cnt <= short_ops ? IMDAU_STALL_SHORT - 2'h1 : IMDAU_STALL_LONG - 2'h1;
      stall <= 1'b1;
    end else if (stall_cnt != 2'h0) begin
      stall_cnt <= stall_cnt - 2'h1;
    end else begin
      stall <= 1'b0;
    end
  end

  // Captured operation and operands' results at issue
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p_op <= IMDAU_OP_NONE;
      p_dst <= '0;
      p_prod <= 64'h0;
      p_quo <= IMDAU_RESET_WORD;
      p_rem <= IMDAU_RESET_WORD;
    end else if (take && (is_mul || is_div)) begin
      p_op <= op;
      p_dst <= dst_idx;
      p_prod <= next_prod;
      p_quo <= next_quo;
      p_rem <= next_rem;
    end
  end

  // Result lands in the last latency clock
  logic land;
  // Multiply repeat is one below latency (divide repeat equals it), so a new take only meets the older result
  // on its landing edge; both proceed and the captured op is still the older
  assign land = (state == IMDAU_ST_BUSY) && (lat_cnt == IMDAU_CNT_ONE);
  logic [63:0] acc;
  assign acc = {top_accum_reg, bottom_accum_reg};

  // Accumulator pair update
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      top_accum_reg <= IMDAU_RESET_WORD;
      bottom_accum_reg <= IMDAU_RESET_WORD;
    end else if (land) begin
      case (p_op)
        IMDAU_OP_SPROD, IMDAU_OP_UPROD: begin
          {top_accum_reg, bottom_accum_reg} <= p_prod;
        end
        IMDAU_OP_MADD, IMDAU_OP_MADDU: begin
          {top_accum_reg, bottom_accum_reg} <= acc + p_prod;
        end
        IMDAU_OP_MSUBS, IMDAU_OP_MSUBU: begin
          {top_accum_reg, bottom_accum_reg} <= acc - p_prod;
        end
        IMDAU_OP_DIVS, IMDAU_OP_UQUO: begin
          top_accum_reg <= p_rem;
          bottom_accum_reg <= p_quo;
        end
        // register product leaves the pair untouched
        default: begin
          top_accum_reg <= top_accum_reg;
        end
      endcase
    end
  end

  // Register-file write from unit: read-accumulator or register product
  always_comb begin
    unit_wr_en = 1'b0;
    unit_wr_idx = dst_idx;
    unit_wr_data = bottom_accum_reg;
    if (land && p_op == IMDAU_OP_PREG) begin
      unit_wr_en = 1'b1;
      unit_wr_idx = p_dst;
      unit_wr_data = p_prod[31:0];
    end else if (take && is_rd) begin
      unit_wr_en = 1'b1;
      unit_wr_data = (op == IMDAU_OP_RDTOP) ? top_accum_reg : bottom_accum_reg;
    end
  end

  // Registered status and operand views
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
      src_a_data <= IMDAU_RESET_WORD;
      src_b_data <= IMDAU_RESET_WORD;
    end else begin
      result_valid <= land;
      // one-cycle operand delivery for the adder and logic unit
      src_a_data <= rd_a;
      src_b_data <= rd_b;
    end
  end

  // Assertions
  a_ready_after_div: assert property (@(posedge core_clk) disable iff (rst)
    (take && is_div) |=> !issue_ready [*8])
    else $error("divide reissue window too short");
  a_short_repeat: assert property (@(posedge core_clk) disable iff (rst)
    (take && is_mul && short_ops) |=> !issue_ready ##1 issue_ready)
    else $error("short repeat not 2");
  a_long_repeat: assert property (@(posedge core_clk) disable iff (rst)
    (take && is_mul && !short_ops) |=> !issue_ready [*2] ##1 issue_ready)
    else $error("long repeat not 3");
  a_short_latency: assert property (@(posedge core_clk) disable iff (rst)
    (take && is_mul && short_ops) |-> ##3 result_valid)
    else $error("short latency not 3");
  a_long_latency: assert property (@(posedge core_clk) disable iff (rst)
    (take && is_mul && !short_ops) |-> ##4 result_valid)
    else $error("long latency not 4");
  a_div_latency: assert property (@(posedge core_clk) disable iff (rst)
    (take && is_div) |-> ##36 result_valid)
    else $error("divide latency not 36");
  a_preg_stall: assert property (@(posedge core_clk) disable iff (rst)
    (take && op == IMDAU_OP_PREG && !short_ops) |=> stall [*2] ##1 !stall)
    else $error("register product stall not 2");
  a_no_stall: assert property (@(posedge core_clk) disable iff (rst)
    (take && (is_div || (is_mul && op != IMDAU_OP_PREG)) && !stall) |=> !stall)
    else $error("unexpected stall");
  a_prod_pair: assert property (@(posedge core_clk) disable iff (rst)
    (land && p_op == IMDAU_OP_SPROD) |=> {top_accum_reg, bottom_accum_reg} == $past(p_prod))
    else $error("product pair wrong");
  a_no_overrun: assert property (@(posedge core_clk) disable iff (rst)
    (take && (is_mul || is_div) && state == IMDAU_ST_BUSY) |-> lat_cnt == IMDAU_CNT_ONE)
    else $error("new operation overran a pending one");
  a_madd_pair: assert property (@(posedge core_clk) disable iff (rst)
    (land && p_op == IMDAU_OP_MADD) |=> acc == $past(acc) + $past(p_prod))
    else $error("accumulate wrong");
  a_preg_keep: assert property (@(posedge core_clk) disable iff (rst)
    (land && p_op == IMDAU_OP_PREG) |=> $stable(acc))
    else $error("register product touched pair");

  c_prod: cover property (@(posedge core_clk) disable iff (rst) take && op == IMDAU_OP_SPROD);
  c_madd_back: cover property (@(posedge core_clk) disable iff (rst)
    (take && op == IMDAU_OP_MADD) ##2 (take && op == IMDAU_OP_MADD));
  c_div: cover property (@(posedge core_clk) disable iff (rst) take && is_div);
  c_rd: cover property (@(posedge core_clk) disable iff (rst) take && is_rd);

endmodule // imdau_unit

// File: verif/imdau_pipe_model.sv
`timescale 1ns/10ps
// Issue logic and outside ALU port of the pipeline, driven at falling edges
module imdau_pipe_model
  import imdau_pkg::*;
(
  input wire logic core_clk,
  input wire logic issue_ready,
  output logic issue_valid,
  output logic [3:0] issue_op,
  output logic [IMDAU_IDX_W-1:0] src_a_idx,
  output logic [IMDAU_IDX_W-1:0] src_b_idx,
  output logic [IMDAU_IDX_W-1:0] dst_idx,
  output logic alu_wr_en,
  output logic [IMDAU_IDX_W-1:0] alu_wr_idx,
  output logic [IMDAU_WORD_W-1:0] alu_wr_data
);
  // Quiet pipeline at time zero
  initial begin
    issue_valid = 1'b0;
    issue_op = IMDAU_OP_NONE;
    src_a_idx = 5'h01;
    src_b_idx = 5'h01;
    dst_idx = 5'h01;
    alu_wr_en = 1'b0;
    alu_wr_idx = 5'h01;
    alu_wr_data = 32'h0;
  end

  // One ALU write; data is scrambled after, so a stale value never looks valid
  task automatic alu_write(input logic [4:0] idx, input logic [31:0] data);
    @(negedge core_clk);
    alu_wr_en = 1'b1;
    alu_wr_idx = idx;
    alu_wr_data = data;
    @(negedge core_clk);
    alu_wr_en = 1'b0;
    alu_wr_data = ~data;
  endtask

  // Offer held until ready is high at a rising edge; returns in the next cycle
  task automatic offer(input logic [3:0] op, input logic [4:0] a, input logic [4:0] b,
                       input logic [4:0] d, output int waited);
    waited = 0;
    @(negedge core_clk);
    issue_valid = 1'b1;
    issue_op = op;
    src_a_idx = a;
    src_b_idx = b;
    dst_idx = d;
    // Bounded so a dead ready line cannot hang the run
    while (issue_ready !== 1'b1 && waited < 100) begin
      @(negedge core_clk);
      waited++;
    end
    @(posedge core_clk);
    @(negedge core_clk);
    issue_valid = 1'b0;
    issue_op = IMDAU_OP_NONE;
  endtask

  // Point both read ports at one register; copies show a cycle later
  task automatic look(input logic [4:0] idx);
    @(negedge core_clk);
    src_a_idx = idx;
    src_b_idx = idx;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
endmodule // imdau_pipe_model

// File: verif/integer_muldiv_accum_unit_bench.sv
`timescale 1ns/10ps
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end

// Self-checking bench with an integer model of registers and accumulators
module integer_muldiv_accum_unit_bench
  import imdau_pkg::*;
;
  logic core_clk;
  logic rst;
  logic issue_valid;
  logic [3:0] issue_op;
  logic [4:0] src_a_idx;
  logic [4:0] src_b_idx;
  logic [4:0] dst_idx;
  logic alu_wr_en;
  logic [4:0] alu_wr_idx;
  logic [31:0] alu_wr_data;
  logic issue_ready;
  logic stall;
  logic result_valid;
  logic [31:0] top_accum_reg;
  logic [31:0] bottom_accum_reg;
  logic [31:0] src_a_data;
  logic [31:0] src_b_data;
  int n_errors;
  int n_checks;
  int last_wait;
  // Model state
  logic [31:0] mreg [32];
  logic [31:0] mtop;
  logic [31:0] mbot;

  imdau_unit DUT (.core_clk(core_clk), .rst(rst), .issue_valid(issue_valid),
    .issue_op(issue_op), .src_a_idx(src_a_idx), .src_b_idx(src_b_idx), .dst_idx(dst_idx),
    .alu_wr_en(alu_wr_en), .alu_wr_idx(alu_wr_idx), .alu_wr_data(alu_wr_data),
    .issue_ready(issue_ready), .stall(stall), .result_valid(result_valid),
    .top_accum_reg(top_accum_reg), .bottom_accum_reg(bottom_accum_reg),
    .src_a_data(src_a_data), .src_b_data(src_b_data));

  imdau_pipe_model pm (.core_clk(core_clk), .issue_ready(issue_ready),
    .issue_valid(issue_valid), .issue_op(issue_op), .src_a_idx(src_a_idx),
    .src_b_idx(src_b_idx), .dst_idx(dst_idx), .alu_wr_en(alu_wr_en),
    .alu_wr_idx(alu_wr_idx), .alu_wr_data(alu_wr_data));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Verdict, reached from the tests and the watchdog
  task automatic close_out;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Operand fits the short class: sign or zero extension of 16 bits
  function automatic bit fits(input logic [31:0] v, input bit sgn);
    return sgn ? (v[31:15] == {17{v[15]}}) : (v[31:16] == 16'h0);
  endfunction

  // Mix of short, boundary, zero and full-width operands
  function automatic logic [31:0] pick(input int sel);
    logic [31:0] v;
    v = $urandom;
    case (sel % 5)
      0: return {{16{v[15]}}, v[15:0]};
      1: return {16'h0, v[15:0]};
      2: return 32'h0;
      3: return 32'h0000_8000;
      default: return v;
    endcase
  endfunction

  task automatic setreg(input int i, input logic [31:0] v);
    pm.alu_write(i[4:0], v);
    mreg[i] = v;
  endtask

  // Both read ports against the model
  task automatic peek(input int i);
    pm.look(i[4:0]);
    `CHK("read port a", mreg[i], src_a_data)
    `CHK("read port b", mreg[i], src_b_data)
  endtask

  // One operation: model result, then timing and values at the ports
  task automatic run(input int op, input int a, input int b, input int d);
    logic [63:0] p;
    logic [63:0] acc;
    longint pa;
    longint pb;
    bit sgn;
    bit sh;
    int lat;
    int rep;
    int stl;
    int kr;
    int kv;
    int ks;
    // signed ops sign-extend, unsigned ops zero-extend
    sgn = op inside {1, 3, 5, 7, 8};
    pa = sgn ? longint'($signed(mreg[a])) : longint'(mreg[a]);
    pb = sgn ? longint'($signed(mreg[b])) : longint'(mreg[b]);
    p = pa * pb;
    // size class from operand values and the op's signedness
    sh = fits(mreg[a], sgn) && fits(mreg[b], sgn);
    lat = (op >= 8) ? 36 : (sh ? 3 : 4);
    rep = (op >= 8) ? 36 : (sh ? 2 : 3);
    stl = (op == 7) ? (sh ? 1 : 2) : 0;
    acc = {mtop, mbot};
    case (op)
      1, 2: acc = p;
      3, 4: acc = acc + p;
      5, 6: acc = acc - p;
      7: mreg[d] = p[31:0];
      // Zero divisor: all-ones quotient, dividend as remainder
      8, 9: acc = (pb == 0) ? {mreg[a], 32'hffff_ffff} : {32'(pa % pb), 32'(pa / pb)};
      10: mreg[d] = mtop;
      default: mreg[d] = mbot;
    endcase
    mtop = acc[63:32];
    mbot = acc[31:0];
    pm.offer(op[3:0], a[4:0], b[4:0], d[4:0], last_wait);
    kr = 0;
    kv = 0;
    ks = 0;
    for (int k = 1; k <= 40 && op < 10; k++) begin
      if (kr == 0 && issue_ready === 1'b1) kr = k;
      if (kv == 0 && result_valid === 1'b1) kv = k;
      if (stall === 1'b1) ks++;
      @(negedge core_clk);
    end
    if (op < 10) begin
      `CHK("latency", lat, kv)
      `CHK("repeat", rep, kr)
      `CHK("stall", stl, ks)
    end
    `CHK("accum", {mtop, mbot}, {top_accum_reg, bottom_accum_reg})
    if (op == 7 || op >= 10) peek(d);
  endtask

  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    mtop = 32'h0;
    mbot = 32'h0;
    rst = 1'b1;
    void'($urandom(32'hfb3c));
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    // Output values straight after reset
    `CHK("ready after reset", 1'b1, issue_ready)
    `CHK("accum after reset", 64'h0, {top_accum_reg, bottom_accum_reg})
    `CHK("flags after reset", 2'b00, {stall, result_valid})
    for (int i = 1; i <= 12; i++) setreg(i, pick(i));
    // Signed-short but unsigned-long operand, and a short positive one
    setreg(13, 32'hffff_8000);
    setreg(14, 32'h0000_7fff);
    // Every operation code, short/long mix, then full width with a zero divisor
    for (int op = 1; op <= 11; op++) begin
      run(op, 13, 14, 15);
      run(op, 4, 2, 16);
    end
    // Random operations and operand refreshes
    for (int n = 0; n < 40; n++) begin
      if (n % 4 == 0) setreg(1 + $urandom % 14, pick($urandom));
      run(1 + $urandom % 11, 1 + $urandom % 14, 1 + $urandom % 14, 1 + $urandom % 16);
    end
    // two short accumulates back to back; the first must still land
    setreg(13, 32'hffff_8000);
    setreg(14, 32'h0000_7fff);
    {mtop, mbot} = {mtop, mbot} + 64'(longint'($signed(mreg[13])) * longint'($signed(mreg[14])))
                   + 64'(longint'($signed(mreg[14])) * longint'($signed(mreg[14])));
    pm.offer(4'h3, 5'd13, 5'd14, 5'd15, last_wait);
    // Short class: ready is back in the cycle the second offer appears
    pm.offer(4'h3, 5'd14, 5'd14, 5'd15, last_wait);
    `CHK("early reissue wait", 0, last_wait)
    repeat (8) @(negedge core_clk);
    `CHK("back to back accum", {mtop, mbot}, {top_accum_reg, bottom_accum_reg})
    close_out();
  end
endmodule // integer_muldiv_accum_unit_bench
